// ### pkg/ipv_pkg.sv
// constants and timing for the interrupt poll and vector sequencer
package ipv_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLKS_PER_STATE = 2;
  localparam int unsigned POLL_STATES = 4;
  localparam int unsigned LONGEST_INSTR_STATES = 21;
  localparam logic [1:0] SAMPLE_STATE = 2'h0;
  localparam logic [1:0] POLL_STATE = 2'h1;
  localparam int unsigned NEXT = 3;
  localparam int unsigned NINT = 5;
  localparam int unsigned NSRC = 8;
  localparam int unsigned NLVL = 4;
  localparam logic [2:0] EXT_IDLE = 3'h3;
  localparam logic [5:0] SWITCH_STATES = 6'h0b;
  localparam logic [5:0] EXT_EXEC_ST = 6'h02;
  localparam logic [5:0] PAGE_ST = 6'h01;
  localparam logic [5:0] FAR_ISR_ST = 6'h08;
  localparam logic [5:0] STACK_NEAR_ST = 6'h04;
  localparam logic [5:0] STACK_FAR_ST = 6'h08;
  localparam logic [2:0] PUSH_SHORT = 3'h2;
  localparam logic [2:0] PUSH_LONG = 3'h4;
  localparam logic [23:0] VEC_BASE = 24'hff0003;
  localparam logic [2:0] VEC_STRIDE_LSB = 3'h0;
  typedef enum logic [1:0] {S_IDLE, S_REQ, S_SWITCH} ipv_state_t;
endpackage

// ### core/ipv_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for the external request pins
module ipv_sync #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_sync
);
  genvar g;
  // each bit gets its own pair of flops; the first is read only by the second
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge i_sys_clk)
      begin
        if (!i_rst_b)
        begin
          meta_r <= RST_VAL[g];
          sync_r <= RST_VAL[g];
        end
        else
        begin
          meta_r <= i_pin[g];
          sync_r <= meta_r;
        end
      end
      assign o_sync[g] = sync_r;
    end
  endgenerate
endmodule

// ### core/ipv_core.sv
`timescale 1ns/1ps
// interrupt sampling, polling, arbitration and vector cycle sequencer
module ipv_core
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ext_irq_zero_n,
  input wire logic i_ext_irq_one_n,
  input wire logic i_timer_two_ext_trigger,
  input wire logic [ipv_pkg::NINT-1:0] i_int_req,
  input wire logic [ipv_pkg::NSRC-1:0] i_irq_enable_reg,
  input wire logic [ipv_pkg::NSRC-1:0] i_irq_priority_high_reg,
  input wire logic [ipv_pkg::NSRC-1:0] i_irq_priority_low_reg,
  input wire logic i_instr_last_state,
  input wire logic i_instr_blocking,
  input wire logic i_return_from_interrupt,
  input wire logic i_irq_stack_mode_bit,
  input wire logic [23:0] i_pc,
  input wire logic [7:0] i_second_status_byte,
  input wire logic i_ext_exec,
  input wire logic i_page_mode,
  input wire logic i_isr_far,
  input wire logic i_ext_stack,
  input wire logic i_ext_stack_far,
  input wire logic [3:0] i_wait_states,
  output logic o_switch_req,
  output logic o_vector_busy,
  output logic o_push_strobe,
  output logic [7:0] o_push_byte,
  output logic o_pc_load,
  output logic [23:0] o_pc_new,
  output logic [ipv_pkg::NLVL-1:0] o_level_active
);
  // pick the winning pending source: {found, index, level}
  function automatic logic [5:0] pick(input logic [7:0] pend, input logic [7:0] hi,
    input logic [7:0] lo);
    logic [5:0] r;
    r = 6'h00;
    for (int i = ipv_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (pend[i] && (!r[5] || {hi[i], lo[i]} >= r[1:0]))
        r = {1'b1, 3'(i), hi[i], lo[i]};
    end
    pick = r;
  endfunction

  // highest level now in service: {any, level}
  function automatic logic [2:0] top_lvl(input logic [3:0] act);
    top_lvl = 3'h0;
    for (int l = 0; l < ipv_pkg::NLVL; l++)
    begin
      if (act[l])
        top_lvl = {1'b1, 2'(l)};
    end
  endfunction

  // byte pushed in a given slot of the vector cycle
  function automatic logic [7:0] push_sel(input logic [2:0] n, input logic lng,
    input logic [23:0] pc, input logic [7:0] psw);
    logic [2:0] k;
    k = lng ? n : n + 3'h2;
    unique case (k)
      3'h0: push_sel = psw;
      3'h1: push_sel = pc[23:16];
      3'h2: push_sel = pc[7:0];
      default: push_sel = pc[15:8];
    endcase
  endfunction

  logic ph_r;
  logic [1:0] st_r;
  logic [2:0] ext_s;
  logic [2:0] ext_lat_r;
  ipv_pkg::ipv_state_t state_r;
  ipv_pkg::ipv_state_t state_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [5:0] sw_len_r;
  logic [2:0] win_idx_r;
  logic [1:0] win_lvl_r;
  logic stk_long_r;
  logic [23:0] pc_cap_r;
  logic [7:0] psw_cap_r;
  logic [3:0] act_r;
  logic switch_req_r;
  logic busy_r;
  logic push_strobe_r;
  logic [7:0] push_byte_r;
  logic pc_load_r;
  logic [23:0] pc_new_r;

  // pins cross into the clock domain before anything looks at them
  ipv_sync #(
    .W(ipv_pkg::NEXT),
    .RST_VAL(ipv_pkg::EXT_IDLE)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_pin({i_timer_two_ext_trigger, i_ext_irq_one_n, i_ext_irq_zero_n}),
    .o_sync(ext_s)
  );

  // state phase and sample window decode
  wire state_end = ph_r;
  wire sample_pt = (st_r == ipv_pkg::SAMPLE_STATE) && !ph_r;
  wire poll_pt = (st_r == ipv_pkg::POLL_STATE) && ph_r;
  wire [2:0] ext_req = {ext_s[2], ~ext_s[1], ~ext_s[0]};

  // internal sources are read live at the poll, pins from the earlier latch
  wire [7:0] pend = {i_int_req, ext_lat_r} & i_irq_enable_reg;
  wire [5:0] win = pick(pend, i_irq_priority_high_reg, i_irq_priority_low_reg);
  wire [2:0] top = top_lvl(act_r);
  wire lvl_blk = top[2] && (win[1:0] <= top[1:0]);
  wire instr_blk = !i_instr_last_state || i_instr_blocking;
  wire go = poll_pt && win[5] && !lvl_blk && !instr_blk && (state_r == ipv_pkg::S_IDLE);

  // switch length grows with the memory conditions of this vector
  wire [5:0] sw_len = ipv_pkg::SWITCH_STATES
    + (i_ext_exec ? ipv_pkg::EXT_EXEC_ST : 6'h00)
    + (i_page_mode ? ipv_pkg::PAGE_ST : 6'h00)
    + (i_isr_far ? ipv_pkg::FAR_ISR_ST : 6'h00)
    + (i_ext_stack ? (i_ext_stack_far ? ipv_pkg::STACK_FAR_ST : ipv_pkg::STACK_NEAR_ST)
      : 6'h00)
    + {2'h0, i_wait_states};

  // push and reload slot decode
  wire [2:0] push_n = stk_long_r ? ipv_pkg::PUSH_LONG : ipv_pkg::PUSH_SHORT;
  wire in_sw = (state_r == ipv_pkg::S_SWITCH);
  wire last_sw = in_sw && (cnt_r == sw_len_r - 6'h01);
  wire push_now = in_sw && !ph_r && (cnt_r < {3'h0, push_n});
  wire load_now = last_sw && !ph_r;
  wire [7:0] push_val = push_sel(cnt_r[2:0], stk_long_r, pc_cap_r, psw_cap_r);
  wire [23:0] vec_addr = ipv_pkg::VEC_BASE + 24'({win_idx_r, ipv_pkg::VEC_STRIDE_LSB});

  // level bookkeeping: set on vector, clear top level on return, set wins
  wire [3:0] set_mask = go ? (4'h1 << win[1:0]) : 4'h0;
  wire [3:0] clr_mask = (i_return_from_interrupt && top[2]) ? (4'h1 << top[1:0]) : 4'h0;
  wire [3:0] act_nxt = (act_r & ~clr_mask) | set_mask;

  // free-running phase and four-state counter
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      ph_r <= 1'b0;
      st_r <= 2'h0;
    end
    else
    begin
      ph_r <= ~ph_r;
      st_r <= state_end ? st_r + 2'h1 : st_r;
    end
  end

  // pins are latched only at the sample point
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      ext_lat_r <= 3'h0;
    else if (sample_pt)
      ext_lat_r <= ext_req;
  end

  // sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      ipv_pkg::S_IDLE:
      begin
        if (go)
          state_nxt = ipv_pkg::S_REQ;
      end
      ipv_pkg::S_REQ:
      begin
        if (state_end)
        begin
          state_nxt = ipv_pkg::S_SWITCH;
          cnt_nxt = 6'h00;
        end
      end
      ipv_pkg::S_SWITCH:
      begin
        if (state_end)
        begin
          cnt_nxt = cnt_r + 6'h01;
          if (last_sw)
            state_nxt = ipv_pkg::S_IDLE;
        end
      end
      default:
        state_nxt = ipv_pkg::S_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      state_r <= ipv_pkg::S_IDLE;
      cnt_r <= 6'h00;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // vector context captured at the winning poll
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      sw_len_r <= ipv_pkg::SWITCH_STATES;
      win_idx_r <= 3'h0;
      win_lvl_r <= 2'h0;
      stk_long_r <= 1'b0;
      pc_cap_r <= 24'h000000;
      psw_cap_r <= 8'h00;
    end
    else if (go)
    begin
      sw_len_r <= sw_len;
      win_idx_r <= win[4:2];
      win_lvl_r <= win[1:0];
      stk_long_r <= i_irq_stack_mode_bit;
      pc_cap_r <= i_pc;
      psw_cap_r <= i_second_status_byte;
    end
  end

  // registered outputs
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      act_r <= 4'h0;
      switch_req_r <= 1'b0;
      busy_r <= 1'b0;
      push_strobe_r <= 1'b0;
      push_byte_r <= 8'h00;
      pc_load_r <= 1'b0;
      pc_new_r <= 24'h000000;
    end
    else
    begin
      act_r <= act_nxt;
      switch_req_r <= (state_nxt == ipv_pkg::S_REQ);
      busy_r <= (state_nxt != ipv_pkg::S_IDLE);
      push_strobe_r <= push_now;
      push_byte_r <= push_now ? push_val : push_byte_r;
      pc_load_r <= load_now;
      pc_new_r <= load_now ? vec_addr : pc_new_r;
    end
  end

  assign o_switch_req = switch_req_r;
  assign o_vector_busy = busy_r;
  assign o_push_strobe = push_strobe_r;
  assign o_push_byte = push_byte_r;
  assign o_pc_load = pc_load_r;
  assign o_pc_new = pc_new_r;
  assign o_level_active = act_r;

  // checks on the sequencer
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sample_period_a: assert property (sample_pt |=> !sample_pt [*7] ##1 sample_pt)
    else $error("sample point not every four states");
  req_width_a: assert property ($rose(o_switch_req) |=> o_switch_req ##1 !o_switch_req)
    else $error("switch request not one state wide");
  req_after_poll_a: assert property ($rose(o_switch_req) |-> $past(poll_pt))
    else $error("switch request not right after a poll");
  switch_len_a: assert property ($fell(o_switch_req) && sw_len_r == ipv_pkg::SWITCH_STATES
    |-> ##21 o_pc_load)
    else $error("context switch not 11 states");
  pin_latch_a: assert property (!$past(sample_pt) |-> $stable(ext_lat_r))
    else $error("pin latch moved outside sample point");
  instr_end_a: assert property ($rose(o_switch_req) |->
    $past(i_instr_last_state && !i_instr_blocking))
    else $error("vector taken mid instruction");
  level_block_a: assert property ($rose(o_switch_req) |->
    (($past(o_level_active) >> win_lvl_r) == 4'h0) && o_level_active[win_lvl_r])
    else $error("vector taken under equal or higher level");
  single_vec_a: assert property (o_vector_busy && $past(o_vector_busy) |->
    (o_level_active & ~$past(o_level_active)) == 4'h0)
    else $error("second vector launched while busy");
  short_push_a: assert property ($rose(o_push_strobe) && !$past(o_push_strobe, 2)
    && !stk_long_r |-> o_push_byte == pc_cap_r[7:0]
    ##2 o_push_strobe && o_push_byte == pc_cap_r[15:8] ##2 !o_push_strobe)
    else $error("short stacking order wrong");
  return_from_interrupt_clear_a: assert property (i_return_from_interrupt && !go && o_level_active != 4'h0
    |=> $countones(o_level_active) == $countones($past(o_level_active)) - 1)
    else $error("return did not reopen a level");
  vec_step_a: assert property (o_pc_load |-> o_pc_new[2:0] == ipv_pkg::VEC_BASE[2:0])
    else $error("vector address off stride");

  pin_zero_c: cover property ($rose(o_switch_req) && win_idx_r == 3'h0);
  long_push_c: cover property (o_push_strobe && stk_long_r);
  return_from_interrupt_c: cover property (i_return_from_interrupt && o_level_active != 4'h0);
  blocked_c: cover property (poll_pt && win[5] && lvl_blk);
endmodule

// ### dv/ipv_cpu_model.sv
// model of the execution unit and the external request pins
`timescale 1ns/1ps
module ipv_cpu_model (
  input wire logic i_sys_clk,
  input wire logic [2:0] i_fire,
  input wire logic i_stall,
  output logic o_pin0_n,
  output logic o_pin1_n,
  output logic o_trig,
  output logic o_last_state
);
  logic [3:0] hold_r [3] = '{4'h0, 4'h0, 4'h0};
  // a fired pin stays active for ten clocks, five states
  always @(posedge i_sys_clk)
  begin
    for (int i = 0; i < 3; i++)
      hold_r[i] <= i_fire[i] ? 4'ha : (hold_r[i] != 4'h0 ? hold_r[i] - 4'h1 : 4'h0);
  end
  // released pins return to their inactive level
  assign o_pin0_n = hold_r[0] == 4'h0;
  assign o_pin1_n = hold_r[1] == 4'h0;
  assign o_trig = hold_r[2] != 4'h0;
  // every poll ends an instruction unless the bench stalls it
  assign o_last_state = !i_stall;
endmodule

// ### dv/testbench.sv
// self-checking bench for the interrupt poll and vector sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module testbench;
  logic clk = 0, rst_b = 0, stall = 0, blk = 0, ret = 0, mode = 0;
  logic ee = 0, pm = 0, far = 0, es = 0, esf = 0;
  logic p0, p1, tr, last, sw, busy, ps, ld;
  logic [2:0] fire = 0;
  logic [3:0] ws = 0, la;
  logic [4:0] req = 0;
  logic [7:0] en = 8'hff, ph = 0, pl = 0, psw = 0, pb;
  logic [23:0] pc = 0, pcn;
  int fail_count = 0, comparisons = 0, cycles = 0, cyc = 0, seed;
  // clock at 50 ns period
  always #25 clk = !clk;
  ipv_cpu_model cpu (.i_sys_clk(clk), .i_fire(fire), .i_stall(stall), .o_pin0_n(p0),
    .o_pin1_n(p1), .o_trig(tr), .o_last_state(last));
  ipv_core dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_ext_irq_zero_n(p0),
    .i_ext_irq_one_n(p1), .i_timer_two_ext_trigger(tr), .i_int_req(req),
    .i_irq_enable_reg(en), .i_irq_priority_high_reg(ph), .i_irq_priority_low_reg(pl),
    .i_instr_last_state(last), .i_instr_blocking(blk), .i_return_from_interrupt(ret),
    .i_irq_stack_mode_bit(mode), .i_pc(pc), .i_second_status_byte(psw), .i_ext_exec(ee),
    .i_page_mode(pm), .i_isr_far(far), .i_ext_stack(es), .i_ext_stack_far(esf),
    .i_wait_states(ws), .o_switch_req(sw), .o_vector_busy(busy), .o_push_strobe(ps),
    .o_push_byte(pb), .o_pc_load(ld), .o_pc_new(pcn), .o_level_active(la));
  // clocks since reset release, and the hang limit
  always @(posedge clk)
  begin
    cyc <= rst_b ? cyc + 1 : 0;
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic setlvl(input int i, input logic [1:0] l);
    ph[i] = l[1];
    pl[i] = l[0];
  endtask
  function automatic int exp_len();
    return 11 + (ee ? 2 : 0) + (pm ? 1 : 0) + (far ? 8 : 0) + (es ? (esf ? 8 : 4) : 0) + ws;
  endfunction
  // wait for a request, then follow the whole vector cycle
  task automatic vec(input int idx);
    int n, len, lds;
    logic [7:0] q[$];
    logic [7:0] e[$];
    n = 0;
    lds = 0;
    len = exp_len();
    if (mode)
    begin
      e.push_back(psw);
      e.push_back(pc[23:16]);
    end
    e.push_back(pc[7:0]);
    e.push_back(pc[15:8]);
    while (sw !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(cyc % 8, 4)
    @(negedge clk);
    `CHK(sw, 1'b1)
    @(negedge clk);
    `CHK(sw, 1'b0)
    for (int t = 1; t <= 2 * len; t++)
    begin
      @(negedge clk);
      `CHK(busy, 1'(t < 2 * len))
      if (ps === 1'b1)
      begin
        `CHK(t, 2 * q.size() + 1)
        q.push_back(pb);
      end
      if (ld === 1'b1)
      begin
        lds++;
        `CHK(t, 2 * len - 1)
        `CHK(pcn, ipv_pkg::VEC_BASE + 24'(8 * idx))
      end
    end
    `CHK(lds, 1)
    `CHK(q.size(), e.size())
    foreach (e[i]) `CHK(q[i], e[i])
  endtask
  task automatic retn();
    @(negedge clk);
    ret = 1;
    @(negedge clk);
    ret = 0;
  endtask
  task automatic none();
    repeat (24) @(negedge clk) `CHK(sw, 1'b0)
  endtask
  initial
  begin
    int idx;
    logic [1:0] lv;
    repeat (6) @(negedge clk);
    rst_b = 1;
    seed = $urandom(32'hb1b5);
    // random vectors over internal sources, modes and extras
    for (int k = 0; k < 6; k++)
    begin
      idx = 3 + $urandom % 5;
      lv = 2'($urandom);
      setlvl(idx, lv);
      {mode, ee, pm, far, es, esf, ws} = 10'($urandom);
      pc = 24'($urandom);
      psw = 8'($urandom);
      if (k == 0)
        {mode, ee, pm, far, es, esf, ws} = 10'h3ff;
      req[idx - 3] = 1;
      vec(idx);
      req = 0;
      `CHK(la, 4'(1 << lv))
      retn();
      `CHK(la, 4'h0)
    end
    // highest level wins, then lowest index within a level, with no extras
    {mode, ee, pm, far, es, esf, ws} = 10'h000;
    setlvl(4, 1);
    setlvl(6, 2);
    req = 5'h0a;
    vec(6);
    req = 0;
    retn();
    setlvl(5, 3);
    setlvl(7, 3);
    req = 5'h14;
    vec(5);
    req = 0;
    retn();
    // blocking by instruction state, level in progress and enable
    ph = 0;
    pl = 0;
    setlvl(3, 2);
    stall = 1;
    req = 5'h01;
    none();
    blk = 1;
    stall = 0;
    none();
    blk = 0;
    vec(3);
    setlvl(4, 2);
    req = 5'h02;
    none();
    setlvl(4, 3);
    vec(4);
    req = 0;
    retn();
    `CHK(la, 4'h4)
    retn();
    en[3] = 0;
    req = 5'h01;
    none();
    req = 0;
    en = 8'hff;
    // each pin source, then a pin dropped while blocked
    for (int i = 0; i < 3; i++)
    begin
      setlvl(i, 1);
      fire[i] = 1;
      @(negedge clk);
      fire = 0;
      vec(i);
      retn();
    end
    stall = 1;
    fire[0] = 1;
    @(negedge clk);
    fire = 0;
    repeat (30) @(negedge clk);
    stall = 0;
    none();
    tally_and_finish();
  end
endmodule
